//--- spinvm_pkg.sv
// Shared constants and types of the serial nonvolatile byte memory slave
package spinvm_pkg;

    // ------------------------------------------------------------------
    // Array geometry and clock rates
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DEPTH = 32768;
    localparam int CLK_HZ = 20_000_000;
    localparam int SCK_MAX_HZ = 20_000_000;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_WRITE_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_MEM_READ = 8'h03;
    localparam logic [7:0] OPC_MEM_WRITE = 8'h02;

    // ------------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------------
    localparam int ST_LOCK_BIT = 7;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL_BIT = 1;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] QUARTER_TOP = 2'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] CNT_STEP = 3'h1;
    localparam logic [14:0] ADDR_STEP = 15'h0001;
    localparam logic LINK_RST_INIT = 1'b1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_OPCODE,
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_WR_DATA,
        PH_RD_DATA,
        PH_WR_STAT,
        PH_RD_STAT,
        PH_IGNORE
    } spinvm_phase_t;

    typedef struct packed {
        logic lock;
        logic [1:0] bp;
        logic wel;
    } spinvm_stat_t;

    typedef struct packed {
        logic mem_we;
        logic [14:0] mem_addr;
        logic [7:0] data;
        logic stat_we;
        logic wel_set;
        logic wel_clr;
    } spinvm_req_t;

    typedef struct packed {
        spinvm_phase_t phase;
        logic is_write;
        logic [6:0] sh;
        logic [2:0] cnt;
        logic [14:0] addr;
    } spinvm_frame_t;

    localparam spinvm_stat_t STAT_RESET = '{lock: 1'b0, bp: BP_NONE, wel: 1'b0};
    localparam spinvm_frame_t FRAME_RESET = '{phase: PH_OPCODE, is_write: 1'b0,
        sh: 7'h00, cnt: 3'h0, addr: 15'h0000};

endpackage

//--- spinvm_sync.sv
// Two-stage level synchroniser into the system clock domain
`timescale 1ns/1ps
module spinvm_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } spinvm_sync_st_t;

    spinvm_sync_st_t st_ff;
    spinvm_sync_st_t nxt_st;

    // First stage feeds only the second stage
    always_comb begin
        nxt_st.meta = d_i;
        nxt_st.q = st_ff.meta;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_o = st_ff.q;
endmodule // spinvm_sync

//--- spinvm_store.sv
// Byte array, status bits and write-latch of the memory, on the serial clock
`timescale 1ns/1ps
module spinvm_store (
    input wire logic clk_i,
    input wire logic link_rst_i,
    input wire spinvm_pkg::spinvm_req_t req_i,
    input wire logic [14:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output spinvm_pkg::spinvm_stat_t stat_o,
    output logic wr_tog_o
);
    typedef struct packed {
        spinvm_pkg::spinvm_stat_t stat;
        logic tog;
    } spinvm_store_st_t;

    logic [7:0] mem [spinvm_pkg::DEPTH];
    spinvm_store_st_t st_ff;
    spinvm_store_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (req_i.wel_set) begin
            nxt_st.stat.wel = 1'b1;
        end
        if (req_i.wel_clr) begin
            nxt_st.stat.wel = 1'b0;
        end
        if (req_i.stat_we) begin
            nxt_st.stat.lock = req_i.data[spinvm_pkg::ST_LOCK_BIT];
            nxt_st.stat.bp = req_i.data[spinvm_pkg::ST_BP_HI:spinvm_pkg::ST_BP_LO];
        end
        if (req_i.mem_we) begin
            nxt_st.tog = ~st_ff.tog;
        end
    end

    always_ff @(posedge clk_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            st_ff <= '{stat: spinvm_pkg::STAT_RESET, tog: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Array content is kept across resets, as a nonvolatile store would
    always_ff @(posedge clk_i) begin
        if (req_i.mem_we) begin
            mem[req_i.mem_addr] <= req_i.data;
        end
    end

    assign rd_data_o = mem[rd_addr_i];
    assign stat_o = st_ff.stat;
    assign wr_tog_o = st_ff.tog;
endmodule // spinvm_store

//--- spinvm_slave.sv
// Serial-link slave of a 32K x 8 nonvolatile byte memory
//
// Notes on behaviour
// - Array holds 32768 bytes, each individually addressable over the link.
// - Any serial clock from zero to 20 MHz; clock may pause anywhere.
// - Link modes 0 and 3 are supported; master may use either, one per selection.
// - Each data byte is written on its last bit, no busy time.
// - Chip select high: standby, inputs ignored, output floats.
// - Serial clock acts only while chip select is low.
// - Input sampled on rising edges, output changed on falling edges.
// - Output driven only during read data and status read, never while hold is low.
// - Lock enable set and protect pin low: status writes rejected.
// - Hold low suspends the transfer and ignores select and clock.
// - Block protection makes top quarter, top half or all read-only.
// - Latch-clear command clears write-enable latch; writes then blocked.
// - First byte after select is the opcode; address, data follow.
// - Two address bytes; top bit ignored, low 15 bits used.
// - Opcode, address and data travel most significant bit first.
// - Unknown opcode: rest of selection ignored, output stays floating.
`timescale 1ns/1ps
module spinvm_slave (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    output logic write_latch_o,
    output logic [1:0] block_protect_o,
    output logic status_lock_enable_o,
    output logic selected_o,
    output logic byte_written_o
);

    // ------------------------------------------------------------------
    // State types of the three clocking regions
    // ------------------------------------------------------------------
    typedef struct packed {
        logic link_rst;
        logic tog_seen;
        logic wr_pulse;
        spinvm_pkg::spinvm_stat_t stat;
        logic sel;
    } spinvm_sys_st_t;

    typedef struct packed {
        logic so;
        logic oe;
    } spinvm_out_st_t;

    spinvm_sys_st_t sys_ff;
    spinvm_sys_st_t nxt_sys;
    spinvm_pkg::spinvm_frame_t fr_ff;
    spinvm_pkg::spinvm_frame_t nxt_fr;
    spinvm_out_st_t out_ff;
    spinvm_out_st_t nxt_out;

    spinvm_pkg::spinvm_req_t req;
    spinvm_pkg::spinvm_stat_t link_stat;
    logic sck_gated;
    logic fr_rst;
    logic [7:0] in_byte;
    logic [7:0] mem_byte;
    logic [7:0] rd_byte;
    logic [7:0] stat_byte;
    logic byte_done;
    logic wr_tog;
    logic [5:0] sync_d;
    logic [5:0] sync_q;
    logic mem_protected;
    logic stat_locked;

    // ------------------------------------------------------------------
    // Link clock and frame reset
    // ------------------------------------------------------------------
    // Hold only moves with the clock low, so the gate never makes a stray edge
    assign sck_gated = sck_i & hold_n_i;

    // Select high keeps the frame logic cleared; select is not used as a
    // clock gate because in mode 3 that would fake a rising edge
    assign fr_rst = (cs_n_i & hold_n_i) | sys_ff.link_rst;

    // ------------------------------------------------------------------
    // Protection checks
    // ------------------------------------------------------------------
    always_comb begin
        unique case (link_stat.bp)
            spinvm_pkg::BP_NONE: begin
                mem_protected = 1'b0;
            end
            spinvm_pkg::BP_QUARTER: begin
                mem_protected = (fr_ff.addr[14:13] == spinvm_pkg::QUARTER_TOP);
            end
            spinvm_pkg::BP_HALF: begin
                mem_protected = fr_ff.addr[14];
            end
            spinvm_pkg::BP_ALL: begin
                mem_protected = 1'b1;
            end
        endcase
    end

    assign stat_locked = link_stat.lock & ~wp_n_i;

    always_comb begin
        stat_byte = 8'h00;
        stat_byte[spinvm_pkg::ST_LOCK_BIT] = link_stat.lock;
        stat_byte[spinvm_pkg::ST_BP_HI:spinvm_pkg::ST_BP_LO] = link_stat.bp;
        stat_byte[spinvm_pkg::ST_WEL_BIT] = link_stat.wel;
    end

    // ------------------------------------------------------------------
    // Frame decoder, rising edges of the gated link clock
    // ------------------------------------------------------------------
    assign in_byte = {fr_ff.sh, si_i};
    assign byte_done = (fr_ff.cnt == spinvm_pkg::LAST_BIT);

    always_comb begin
        nxt_fr = fr_ff;
        req = '0;
        req.mem_addr = fr_ff.addr;
        req.data = in_byte;
        nxt_fr.sh = in_byte[6:0];
        nxt_fr.cnt = fr_ff.cnt + spinvm_pkg::CNT_STEP;
        if (byte_done) begin
            unique case (fr_ff.phase)
                spinvm_pkg::PH_OPCODE: begin
                    // First full byte of a selection is always the opcode
                    unique case (in_byte)
                        spinvm_pkg::OPC_WRITE_LATCH_SET: begin
                            req.wel_set = 1'b1;
                            nxt_fr.phase = spinvm_pkg::PH_IGNORE;
                        end
                        spinvm_pkg::OPC_WRITE_LATCH_CLEAR: begin
                            req.wel_clr = 1'b1;
                            nxt_fr.phase = spinvm_pkg::PH_IGNORE;
                        end
                        spinvm_pkg::OPC_STATUS_READ: begin
                            nxt_fr.phase = spinvm_pkg::PH_RD_STAT;
                        end
                        spinvm_pkg::OPC_STATUS_WRITE: begin
                            nxt_fr.phase = spinvm_pkg::PH_WR_STAT;
                        end
                        spinvm_pkg::OPC_MEM_READ: begin
                            nxt_fr.is_write = 1'b0;
                            nxt_fr.phase = spinvm_pkg::PH_ADDR_HI;
                        end
                        spinvm_pkg::OPC_MEM_WRITE: begin
                            nxt_fr.is_write = 1'b1;
                            nxt_fr.phase = spinvm_pkg::PH_ADDR_HI;
                        end
                        default: begin
                            nxt_fr.phase = spinvm_pkg::PH_IGNORE;
                        end
                    endcase
                end
                spinvm_pkg::PH_ADDR_HI: begin
                    nxt_fr.addr[14:8] = in_byte[6:0];
                    nxt_fr.phase = spinvm_pkg::PH_ADDR_LO;
                end
                spinvm_pkg::PH_ADDR_LO: begin
                    nxt_fr.addr[7:0] = in_byte;
                    if (fr_ff.is_write) begin
                        nxt_fr.phase = spinvm_pkg::PH_WR_DATA;
                    end else begin
                        nxt_fr.phase = spinvm_pkg::PH_RD_DATA;
                    end
                end
                spinvm_pkg::PH_WR_DATA: begin
                    // Committed on the byte's last edge; address wraps at the top
                    req.mem_we = link_stat.wel & ~mem_protected;
                    nxt_fr.addr = fr_ff.addr + spinvm_pkg::ADDR_STEP;
                end
                spinvm_pkg::PH_RD_DATA: begin
                    nxt_fr.addr = fr_ff.addr + spinvm_pkg::ADDR_STEP;
                end
                spinvm_pkg::PH_WR_STAT: begin
                    req.stat_we = link_stat.wel & ~stat_locked;
                    nxt_fr.phase = spinvm_pkg::PH_IGNORE;
                end
                spinvm_pkg::PH_RD_STAT: begin
                    nxt_fr.phase = spinvm_pkg::PH_RD_STAT;
                end
                spinvm_pkg::PH_IGNORE: begin
                    nxt_fr.phase = spinvm_pkg::PH_IGNORE;
                end
            endcase
        end
    end

    // Partial bytes die here: nothing is committed before the eighth edge
    always_ff @(posedge sck_gated or posedge fr_rst) begin
        if (fr_rst) begin
            fr_ff <= spinvm_pkg::FRAME_RESET;
        end else begin
            fr_ff <= nxt_fr;
        end
    end

    // ------------------------------------------------------------------
    // Array and status store
    // ------------------------------------------------------------------
    spinvm_store u_store (
        .clk_i(sck_gated),
        .link_rst_i(sys_ff.link_rst),
        .req_i(req),
        .rd_addr_i(fr_ff.addr),
        .rd_data_o(mem_byte),
        .stat_o(link_stat),
        .wr_tog_o(wr_tog)
    );

    // ------------------------------------------------------------------
    // Serial output, falling edges of the gated link clock
    // ------------------------------------------------------------------
    always_comb begin
        if (fr_ff.phase == spinvm_pkg::PH_RD_STAT) begin
            rd_byte = stat_byte;
        end else begin
            rd_byte = mem_byte;
        end
    end

    always_comb begin
        nxt_out.oe = (fr_ff.phase == spinvm_pkg::PH_RD_DATA)
            || (fr_ff.phase == spinvm_pkg::PH_RD_STAT);
        nxt_out.so = rd_byte[~fr_ff.cnt];
    end

    always_ff @(negedge sck_gated or posedge fr_rst) begin
        if (fr_rst) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign so_o = out_ff.so;
    // Enable also cut by hold, so the pin floats the moment hold drops
    assign so_oe_o = out_ff.oe & hold_n_i;

    // ------------------------------------------------------------------
    // Crossing into the system clock domain
    // ------------------------------------------------------------------
    assign sync_d = {link_stat, wr_tog, ~cs_n_i};

    spinvm_sync #(
        .W(6)
    ) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i(sync_d),
        .q_o(sync_q)
    );

    always_comb begin
        nxt_sys = sys_ff;
        nxt_sys.link_rst = 1'b0;
        // Status word taken only while deselected: it cannot move then,
        // so its bits are never caught half-way through a change
        if (!sync_q[0]) begin
            nxt_sys.stat = sync_q[5:2];
        end
        nxt_sys.tog_seen = sync_q[1];
        nxt_sys.wr_pulse = sync_q[1] ^ sys_ff.tog_seen;
        nxt_sys.sel = sync_q[0];
    end

    // Link reset follows the system reset; it stands in for power-on
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sys_ff <= '{link_rst: spinvm_pkg::LINK_RST_INIT, tog_seen: 1'b0,
                wr_pulse: 1'b0, stat: spinvm_pkg::STAT_RESET, sel: 1'b0};
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    assign write_latch_o = sys_ff.stat.wel;
    assign block_protect_o = sys_ff.stat.bp;
    assign status_lock_enable_o = sys_ff.stat.lock;
    assign selected_o = sys_ff.sel;
    assign byte_written_o = sys_ff.wr_pulse;

endmodule // spinvm_slave

//--- spinvm_slave_sva.sv
// Concurrent checks on the pins of the serial memory slave
`timescale 1ns/1ps
module spinvm_slave_sva (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic write_latch_o,
    input wire logic [1:0] block_protect_o,
    input wire logic status_lock_enable_o,
    input wire logic selected_o,
    input wire logic byte_written_o
);
    // ----------------------------------------------------------------
    // Output level seen at each rising serial edge
    // ----------------------------------------------------------------
    logic so_at_rise_ff;
    always_ff @(posedge sck_i) begin
        so_at_rise_ff <= so_o;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    standby_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cs_n_i |-> !so_oe_o) else $error("output enabled in standby");
    hold_float_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !hold_n_i |-> !so_oe_o) else $error("output enabled in hold");
    select_sync_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !cs_n_i [*4] |-> selected_o) else $error("selection not seen");
    deselect_sync_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cs_n_i [*4] |-> !selected_o) else $error("standby not seen");
    latch_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !write_latch_o [*8] |-> !byte_written_o) else $error("commit with latch clear");
    protect_all_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (block_protect_o == spinvm_pkg::BP_ALL) [*8] |-> !byte_written_o)
        else $error("commit into protected array");
    field_latch_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $changed(block_protect_o) |-> write_latch_o) else $error("status change without latch");
    status_lock_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (status_lock_enable_o && !wp_n_i) [*6] |=> $stable(block_protect_o))
        else $error("locked status changed");
    commit_pulse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        byte_written_o |=> !byte_written_o) else $error("commit pulse too long");
    so_fall_only_a: assert property (@(negedge sck_i) disable iff (!resetn_i)
        (so_oe_o && hold_n_i && !cs_n_i) |-> so_o == so_at_rise_ff)
        else $error("output changed on rising edge");
endmodule // spinvm_slave_sva

bind spinvm_slave spinvm_slave_sva u_sva (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck_i),
    .cs_n_i(cs_n_i), .si_i(si_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .write_latch_o(write_latch_o), .block_protect_o(block_protect_o),
    .status_lock_enable_o(status_lock_enable_o), .selected_o(selected_o),
    .byte_written_o(byte_written_o));

//--- spinvm_master_model.sv
// Behavioural link master facing the memory slave
`timescale 1ns/1ps
module spinvm_master_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    logic idle_lvl;
    logic so_last;
    logic so_seen;
    // Floating line reads back inverted so a stale bit never passes
    always @(so_i or so_oe_i) begin
        if (so_oe_i) begin
            so_last = so_i;
        end
    end
    assign so_seen = so_oe_i ? so_i : ~so_last;
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
        idle_lvl = 1'b0;
        so_last = 1'b0;
    end
    task automatic start(input logic m3);
        idle_lvl = m3;
        sck_o = m3;
        #7;
        cs_n_o = 1'b0;
        #7;
    endtask
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck_o = 1'b0;
            si_o = tx[i];
            #3;
            sck_o = 1'b1;
            rx[i] = so_seen;
            #3;
        end
        sck_o = idle_lvl;
    endtask
    task automatic stop();
        #5;
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #250;
    endtask
    // Called only with the clock low, in mode 0
    task automatic hold_with_noise();
        hold_n_o = 1'b0;
        #5;
        repeat (3) begin
            sck_o = 1'b1;
            si_o = ~si_o;
            #3;
            sck_o = 1'b0;
            #3;
        end
        cs_n_o = 1'b1;
        #10;
        cs_n_o = 1'b0;
        #5;
    endtask
    task automatic hold_release();
        hold_n_o = 1'b1;
        #5;
    endtask
endmodule // spinvm_master_model

//--- spi_nv_byte_memory_slave_tb_top.sv
// Self-checking bench of the memory slave driven by the link master model
`timescale 1ns/1ps
module spi_nv_byte_memory_slave_tb_top;
    logic clk_i, resetn_i, wp_n_i, mode3;
    logic sck, cs_n, si, hold_n, so, so_oe, write_latch, lock_en, selected, byte_written;
    logic [1:0] bp;
    logic [7:0] rx, d;
    int n_fail = 0;
    int n_compared = 0;
    int n_pulse = 0;
    int p;

    spinvm_slave DUT (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe),
        .write_latch_o(write_latch), .block_protect_o(bp), .status_lock_enable_o(lock_en),
        .selected_o(selected), .byte_written_o(byte_written));
    spinvm_master_model m (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
        .so_i(so), .so_oe_i(so_oe));

    always @(posedge clk_i) begin
        if (byte_written === 1'b1) begin
            n_pulse++;
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        m.start(mode3);
        m.bits(op, 8, rx);
        m.stop();
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v, input int n);
        m.start(mode3);
        m.bits(spinvm_pkg::OPC_MEM_WRITE, 8, rx);
        m.bits(a[15:8], 8, rx);
        m.bits(a[7:0], 8, rx);
        m.bits(v, n, rx);
        m.stop();
    endtask
    task automatic rd_open(input logic [15:0] a);
        m.start(mode3);
        m.bits(spinvm_pkg::OPC_MEM_READ, 8, rx);
        m.bits(a[15:8], 8, rx);
        m.bits(a[7:0], 8, rx);
    endtask
    task automatic rd(input logic [15:0] a);
        rd_open(a);
        m.bits(8'h00, 8, d);
        m.stop();
    endtask
    task automatic swr(input logic [7:0] v);
        cmd(spinvm_pkg::OPC_WRITE_LATCH_SET);
        m.start(mode3);
        m.bits(spinvm_pkg::OPC_STATUS_WRITE, 8, rx);
        m.bits(v, 8, rx);
        m.stop();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_mem();
        for (int k = 0; k < 2; k++) begin
            mode3 = k[0];
            p = n_pulse;
            cmd(spinvm_pkg::OPC_WRITE_LATCH_SET);
            wr(16'hFFFF, 8'hC3 ^ k[7:0], 8);
            wr(16'h8000, 8'h3C ^ k[7:0], 8);
            check("commit pulses", 8'(p + 2), 8'(n_pulse));
            rd_open(16'h7FFF);
            m.bits(8'h00, 8, d);
            check("top byte", 8'hC3 ^ k[7:0], d);
            m.bits(8'h00, 8, d);
            check("wrapped byte", 8'h3C ^ k[7:0], d);
            m.stop();
        end
        $display("test t_mem done");
    endtask
    task automatic t_latch();
        mode3 = 1'b0;
        cmd(spinvm_pkg::OPC_WRITE_LATCH_SET);
        wr(16'h1234, 8'h11, 8);
        p = n_pulse;
        cmd(spinvm_pkg::OPC_WRITE_LATCH_CLEAR);
        check("latch", 8'h00, {7'h00, write_latch});
        wr(16'h1234, 8'hEE, 8);
        rd(16'h1234);
        check("blocked byte", 8'h11, d);
        check("commit pulses", 8'(p), 8'(n_pulse));
        $display("test t_latch done");
    endtask
    task automatic t_protect();
        logic [14:0] base [3];
        base = '{15'h6000, 15'h4000, 15'h0000};
        mode3 = 1'b1;
        swr(8'h00);
        for (int b = 0; b < 3; b++) begin
            wr({1'b0, base[b]}, 8'h00, 8);
        end
        for (int b = 1; b < 4; b++) begin
            swr({4'h0, b[1:0], 2'h0});
            check("protect field", 8'(b), {6'h00, bp});
            wr({1'b0, base[b-1]}, 8'hA0 | 8'(b), 8);
            rd({1'b0, base[b-1]});
            check("protected byte", 8'h00, d);
            if (b < 3) begin
                wr({1'b0, base[b-1] - 15'h0001}, 8'h50 | 8'(b), 8);
                rd({1'b0, base[b-1] - 15'h0001});
                check("open byte", 8'h50 | 8'(b), d);
            end
        end
        swr(8'h00);
        $display("test t_protect done");
    endtask
    task automatic t_lock();
        mode3 = 1'b1;
        swr(8'h80);
        check("lock bit", 8'h01, {7'h00, lock_en});
        @(posedge clk_i);
        #1;
        wp_n_i = 1'b0;
        swr(8'h0C);
        check("locked field", 8'h00, {6'h00, bp});
        m.start(mode3);
        m.bits(spinvm_pkg::OPC_STATUS_READ, 8, rx);
        m.bits(8'h00, 8, d);
        m.stop();
        check("status byte", 8'h82, d);
        @(posedge clk_i);
        #1;
        wp_n_i = 1'b1;
        swr(8'h00);
        check("lock released", 8'h00, {7'h00, lock_en});
        $display("test t_lock done");
    endtask
    task automatic t_odd();
        mode3 = 1'b0;
        m.start(mode3);
        m.bits(8'hAB, 8, rx);
        repeat (3) m.bits(8'h00, 8, rx);
        check("enable after bad opcode", 8'h00, {7'h00, so_oe});
        m.stop();
        p = n_pulse;
        wr(16'h1234, 8'h77, 5);
        rd(16'h1234);
        check("partial byte", 8'h11, d);
        check("commit pulses", 8'(p), 8'(n_pulse));
        wr(16'h1234, 8'h77, 8);
        rd(16'h1234);
        check("byte after partial", 8'h77, d);
        $display("test t_odd done");
    endtask
    task automatic t_hold();
        mode3 = 1'b0;
        wr(16'h0100, 8'h96, 8);
        wr(16'h0101, 8'h69, 8);
        rd_open(16'h0100);
        m.bits(8'h00, 8, d);
        check("before hold", 8'h96, d);
        m.hold_with_noise();
        check("enable in hold", 8'h00, {7'h00, so_oe});
        m.hold_release();
        m.bits(8'h00, 8, d);
        check("after hold", 8'h69, d);
        m.stop();
        check("standby", 8'h00, {6'h00, so_oe, selected});
        $display("test t_hold done");
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        resetn_i = 1'b0;
        wp_n_i = 1'b1;
        mode3 = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        repeat (3) @(posedge clk_i);
        t_mem();
        t_latch();
        t_protect();
        t_lock();
        t_odd();
        t_hold();
        end_of_test();
    end
    initial begin
        #500000;
        $display("watchdog expired");
        n_fail++;
        end_of_test();
    end
endmodule // spi_nv_byte_memory_slave_tb_top
